// *** verilog/csm_pkg.sv ***
// constants shared by the serial memory design
`default_nettype none
package csm_pkg;
  localparam int REG_COUNT     = 64;    // independent circulating loops
  localparam int REG_BITS      = 256;   // bits per loop
  localparam int SEL_W         = 6;     // register select width
  localparam int POS_W         = 8;     // bit position counter width
  localparam int FIFO_W        = 8;     // write fifo word: select + data + pad
  localparam int FIFO_D        = 16;    // write fifo depth
  localparam int STARTUP_SHIFTS = 4000; // shifts before the reference settles
  localparam logic [11:0] STARTUP_RST = 12'h000;
  localparam logic [POS_W-1:0] POS_RST = 8'h00;
  localparam int WSEL_LSB      = 0;     // select field position in fifo word
  localparam int WDAT_BIT      = 6;     // data bit position in fifo word
endpackage
`default_nettype wire

// *** verilog/csm_fifo.sv ***
// parameterised valid/ready fifo carrying pending bit writes
`timescale 1ns/1ns
`default_nettype none
module csm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign out_valid = (wr_r != rd_r);
  assign out_data  = mem[rd_r[AW-1:0]];

  // storage written without reset, pointers reset
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/csm_core.sv ***
// circulating serial memory: 64 loops of 256 bits with exposed-bit access
`timescale 1ns/1ns
`default_nettype none
module csm_core
  import csm_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [3:0]       phase_clk,
  input  wire logic [SEL_W-1:0] register_select_lines,
  input  wire logic             chip_enable,
  input  wire logic             chip_select,
  input  wire logic             write_enable,
  input  wire logic             data_in,
  output logic                  data_out,
  output logic                  data_out_oe,
  output logic                  startup_done,
  output logic                  write_ready
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int NPIN = 4 + SEL_W + 4;
  wire  [NPIN-1:0] pin_raw = {phase_clk, register_select_lines,
                              chip_enable, chip_select, write_enable,
                              data_in};
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  logic [NPIN-1:0] pin_r;   // filtered value: updates when s2 and s3 agree

  // three stages; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    s1_r <= pin_raw;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_filt
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          pin_r[g] <= 1'b0;
        end else if (s2_r[g] == s3_r[g]) begin
          pin_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate

  wire [3:0]       ph_f  = pin_r[NPIN-1 -: 4];
  wire [SEL_W-1:0] sel_f = pin_r[4 +: SEL_W];
  wire             ce_f  = pin_r[3];
  wire             cs_f  = pin_r[2];
  wire             we_f  = pin_r[1];
  wire             din_f = pin_r[0];

  // ****************************************************************
  // shift detection
  // ****************************************************************
  logic [3:0] ph_prev_r;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ph_prev_r <= 4'h0;
    end else begin
      ph_prev_r <= ph_f;
    end
  end

  wire shift_go = (ph_f[1] && !ph_prev_r[1]) || (ph_f[3] && !ph_prev_r[3]);

  // ****************************************************************
  // storage
  // ****************************************************************
  // loop storage array
  logic [REG_BITS-1:0] loop_r [REG_COUNT];
  logic [POS_W-1:0]    pos_r;   // exposed bit position, common to all loops

  // rotating a position pointer is the same as rotating every loop by one
  // move onward on shift
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pos_r <= POS_RST;
    end else if (shift_go) begin
      pos_r <= pos_r + 1'b1;
    end
  end

  // ****************************************************************
  // access decode
  // ****************************************************************
  // one-hot decode, reused by write path and test of selection
  function automatic logic [REG_COUNT-1:0] dec64(input logic [SEL_W-1:0] s);
    dec64 = '0;
    dec64[s] = 1'b1;
  endfunction

  wire access = ce_f && cs_f && !shift_go;
  wire [REG_COUNT-1:0] sel_hot = dec64(sel_f);

  // ****************************************************************
  // write queue
  // ****************************************************************
  // writes are queued so a burst of requests is absorbed; the fifo drains
  // only between shifts, so a write still queued at a shift edge lands at the next bit position
  logic [FIFO_W-1:0] q_in;
  logic [FIFO_W-1:0] q_out;
  logic              q_in_ready;
  logic              q_out_valid;
  logic              we_prev_r;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      we_prev_r <= 1'b0;
    end else begin
      we_prev_r <= we_f && access;
    end
  end

  // one entry per write-enable rising while accessing
  wire q_push = access && we_f && !we_prev_r;
  assign q_in = {1'b0, din_f, sel_f};

  wire q_pop = q_out_valid && !shift_go;

  csm_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_wq (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_data   (q_in),
    .in_valid  (q_push),
    .in_ready  (q_in_ready),
    .out_data  (q_out),
    .out_valid (q_out_valid),
    .out_ready (!shift_go)
  );

  wire [REG_COUNT-1:0] wr_hot = dec64(q_out[WSEL_LSB +: SEL_W]);

  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_loop
      always_ff @(posedge core_clk) begin
        if (q_pop && wr_hot[g]) begin
          loop_r[g][pos_r] <= q_out[WDAT_BIT];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // read path and start-up count
  // ****************************************************************
  // read bypasses a queued write to the same bit at the queue head
  wire bypass = q_out_valid && (q_out[WSEL_LSB +: SEL_W] == sel_f);
  wire rd_bit = bypass ? q_out[WDAT_BIT] : loop_r[sel_f][pos_r];
  wire unused_hot = |sel_hot;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      data_out    <= 1'b0;
      data_out_oe <= 1'b0;
      write_ready <= 1'b0;
    end else begin
      data_out    <= access ? rd_bit : 1'b0;
      data_out_oe <= access && unused_hot;
      write_ready <= q_in_ready;
    end
  end

  logic [11:0] boot_cnt_r;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      boot_cnt_r   <= STARTUP_RST;
      startup_done <= 1'b0;
    end else if (shift_go && !startup_done) begin
      boot_cnt_r <= boot_cnt_r + 1'b1;
      if (boot_cnt_r == 12'(STARTUP_SHIFTS - 1)) begin
        startup_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/csm_core_sva.sv ***
// concurrent checks on the serial memory core ports
`timescale 1ns/1ns
`default_nettype none
module csm_core_sva
  import csm_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             reset_n,
  input wire logic [3:0]       phase_clk,
  input wire logic [SEL_W-1:0] register_select_lines,
  input wire logic             chip_enable,
  input wire logic             chip_select,
  input wire logic             write_enable,
  input wire logic             data_in,
  input wire logic             data_out,
  input wire logic             data_out_oe,
  input wire logic             startup_done
);
  wire acc = chip_enable && chip_select;
  logic [12:0] shifts_r;
  logic [3:0]  ph_r;
  // raw phase two/four rises; the core lags the pins, so never leads this
  always_ff @(posedge core_clk) begin
    ph_r <= phase_clk;
    if (!reset_n) shifts_r <= 13'h0000;
    else if ((|(phase_clk & ~ph_r & 4'hA)) && shifts_r != 13'h1FFF)
      shifts_r <= shifts_r + 13'h0001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_held;
    (acc && !write_enable && $stable(phase_clk)
     && $stable(register_select_lines))[*8];
  endsequence
  sequence s_wr;
    acc && data_out_oe && $rose(write_enable) ##1 (acc && write_enable
     && $stable(data_in) && $stable(register_select_lines))[*8];
  endsequence
  a_oe_follows_access: assert property (s_held |=> data_out_oe)
    else $error("enable missing in held access");
  a_write_shows: assert property (s_wr |=> data_out == data_in)
    else $error("written bit not shown");
  a_read_steady: assert property (s_held |=> $stable(data_out))
    else $error("read disturbed the bit");
  a_idle_quiet: assert property ((!acc)[*8] |-> !data_out_oe)
    else $error("driven while idle");
  a_data_gated: assert property (!data_out_oe |-> !data_out)
    else $error("data high while undriven");
  a_oe_cause: assert property ($rose(data_out_oe) |-> $past(acc, 2))
    else $error("enable rose without access");
  a_start_sticky: assert property (startup_done |=> startup_done)
    else $error("start-up flag dropped");
  a_start_count: assert property (startup_done |->
    shifts_r >= 13'(STARTUP_SHIFTS)) else $error("start-up flag early");
endmodule
bind csm_core csm_core_sva chk (.*);
`default_nettype wire

// *** dv/csm_ctrl_model.sv ***
// controller model: rotates the four clock phases while run is high
`timescale 1ns/1ns
`default_nettype none
module csm_ctrl_model (
  input  wire logic core_clk,
  input  wire logic run,
  output logic [3:0] phase_clk,
  output int         shifts
);
  int tick = 0;
  initial phase_clk = 4'h1;
  initial shifts = 0;
  // phases frozen while run is low so accesses fall between shifts
  always @(posedge core_clk) if (run) begin
    tick = (tick + 1) % 4;
    if (tick == 0) begin
      phase_clk <= {phase_clk[2:0], phase_clk[3]};
      shifts <= shifts + ((phase_clk[0] | phase_clk[2]) ? 1 : 0);
    end
  end
endmodule
`default_nettype wire

// *** dv/ccd_recirculating_serial_memory_test.sv ***
// self-checking bench for the serial memory core
`timescale 1ns/1ns
`default_nettype none
module ccd_recirculating_serial_memory_test;
  import csm_pkg::*;
  logic core_clk = 0, reset_n = 0, run = 0, chip_enable = 0, oe_r = 0;
  logic chip_select = 0, write_enable = 0, data_in = 0;
  logic data_out, data_out_oe, startup_done, write_ready;
  logic [SEL_W-1:0] register_select_lines = 6'h00;
  logic [3:0] phase_clk;
  logic [31:0] seed = 32'h00001B36;
  int shifts, n_fail = 0, n_compared = 0, cycles = 0;
  logic exp_q[$];
  csm_ctrl_model ctrl (.core_clk(core_clk), .run(run),
    .phase_clk(phase_clk), .shifts(shifts));
  csm_core DUT (.core_clk(core_clk), .reset_n(reset_n),
    .phase_clk(phase_clk), .register_select_lines(register_select_lines),
    .chip_enable(chip_enable), .chip_select(chip_select),
    .write_enable(write_enable), .data_in(data_in), .data_out(data_out),
    .data_out_oe(data_out_oe), .startup_done(startup_done),
    .write_ready(write_ready));
  initial forever #10 core_clk = ~core_clk;
  // xorshift step for the random select and data fields
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // checks on the settled edge; each new read takes the oldest note
  always @(negedge core_clk) begin
    oe_r <= data_out_oe;
    cycles++;
    if (data_out_oe && !oe_r && exp_q.size() > 0)
      cmp_bit(data_out, exp_q.pop_front());
    if (cycles == 60000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic shift_n(input int n);
    int t;
    t = shifts + n;
    run <= 1'b1;
    while (shifts < t) @(posedge core_clk);
    run <= 1'b0;
    repeat (8) @(posedge core_clk);
    $display("shift stage done at %0t", $time);
  endtask
  // access with optional read note, then optional write
  task automatic access(input logic [SEL_W-1:0] sel, input logic wr,
    input logic d, input logic chk, input logic e);
    if (chk) exp_q.push_back(e);
    register_select_lines <= sel;
    chip_enable <= 1'b1;
    chip_select <= 1'b1;
    repeat (10) @(posedge core_clk);
    if (wr) begin
      data_in <= d;
      write_enable <= 1'b1;
      repeat (10) @(posedge core_clk);
      write_enable <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    chip_enable <= 1'b0;
    chip_select <= 1'b0;
    data_in <= ~d;
    repeat (10) @(posedge core_clk);
  endtask
  initial begin
    logic [SEL_W-1:0] sel[8];
    logic v[8][2];
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    shift_n(STARTUP_SHIFTS);
    cmp_bit(startup_done, 1'b1);
    cmp_bit(write_ready, 1'b1);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      sel[i] = {i[2:0], seed[2:0]};
      v[i][0] = seed[8];
      v[i][1] = seed[9];
      access(sel[i], 1'b1, v[i][0], 1'b0, 1'b0);
      access(sel[i], 1'b0, 1'b0, 1'b1, v[i][0]);
    end
    shift_n(1);
    for (int i = 0; i < 8; i++) access(sel[i], 1'b1, v[i][1], 1'b0, 1'b0);
    shift_n(255);
    for (int i = 0; i < 8; i++) access(sel[i], 1'b0, 1'b0, 1'b1, v[i][0]);
    shift_n(1);
    for (int i = 0; i < 8; i++) access(sel[i], 1'b1, ~v[i][1], 1'b1, v[i][1]);
    shift_n(256);
    for (int i = 0; i < 8; i++) access(sel[i], 1'b0, 1'b0, 1'b1, ~v[i][1]);
    repeat (4) @(posedge core_clk);
    summarize();
  end
endmodule
`default_nettype wire
